// ===== gyo_core.sv
// Output word formatting, sample timing, range and averaging filter.
// Assumes converter samples arrive synchronously with raw_valid at 2048 SPS.
`timescale 1ns/10ps

// Contract
// RL1 - Each output word flags new data while an unread sample is held.
// RL2 - Each output word flags error when any diagnostic status bit is set.
// RL3 - New-data flag bit 15, error bit 14, data right-justified, flag clears on read.
// RL4 - Supply word is 12-bit unsigned, 1.8315 mV per LSB.
// RL5 - Rate word is 14-bit signed, 0.07326 deg/s at widest range, scales with range.
// RL6 - Angle word is 14-bit unsigned, 0.03663 deg, wraps past maximum code to zero.
// RL7 - Temperature word is 12-bit signed, 0.1453 C per LSB, zero at 25 C.
// RL8 - Auxiliary input word is 12-bit unsigned, 610.5 uV per LSB.
// RL9 - Period low byte zero gives 2048 samples per second.
// RL10 - Otherwise period is time base times increment plus one.
// RL11 - Period bit 7 selects 1.953 ms or 60.54 ms base; upper byte unused.
// RL12 - Range field bits 10:8; code 100 is 320 deg/s and default.
// RL13 - Range 010 is 160 deg/s; tap field kept at least 2.
// RL14 - Range 001 is 80 deg/s; tap field kept at least 4.
// RL15 - Bit 7 sets analog pole: one 330 Hz, zero 50 Hz.
// RL16 - Bits 2:0 give exponent m; each stage uses 2^m taps.
// RL17 - Two equal cascaded moving averages form triangular weighting.
// RL18 - Host writes range before tap count when changing range.
module gyo_core import gyo_pkg::*; #(
    parameter int FAST_CYC = FAST_SMPL_CYC,
    parameter int BASE_FAST_CYC = TB_FAST_CYC,
    parameter int BASE_SLOW_CYC = TB_SLOW_CYC
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic raw_valid,
    input wire gyo_raw_type raw,
    input wire logic [15:0] diagnostic_status,
    input wire logic [6:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    output logic reg_rvalid,
    output logic sample_tick,
    output logic pole_wide,
    output logic [2:0] range_sel
);

    if (FAST_CYC < 1 || BASE_FAST_CYC < 1 || BASE_SLOW_CYC < 1 ||
        longint'(BASE_SLOW_CYC) * 128 > 64'h00000000ffffffff) begin
        $error("gyo_core: timing counts out of range for period counter");
    end

    // ****************************************
    // Functions
    // ****************************************
    function automatic logic [31:0] period_cycles(input logic [7:0] sp);
        logic [31:0] base;
        logic [31:0] n;
        base = sp[TB_SEL_BIT] ? 32'(BASE_SLOW_CYC) : 32'(BASE_FAST_CYC);
        n = {25'h0, sp[6:0]} + 32'h1;
        if (sp == 8'h00)
            return 32'(FAST_CYC);                                            // RL9
        return base * n;
    endfunction

    function automatic logic [13:0] scale_rate(input logic signed [15:0] v,
                                               input logic [2:0] rng);
        logic signed [15:0] s;
        s = v;
        if (rng == RNG_320)
            s = v >>> 2;
        else if (rng == RNG_160)
            s = v >>> 1;
        if (s > 16'sh1fff)
            return 14'h1fff;
        if (s < -16'sh2000)
            return 14'h2000;
        return s[13:0];
    endfunction

    function automatic logic [2:0] min_taps(input logic [2:0] rng);
        if (rng == RNG_80)
            return MIN_TAP_80;
        if (rng == RNG_160)
            return MIN_TAP_160;
        return 3'h0;
    endfunction

    // ****************************************
    // Control registers
    // ****************************************
    logic [7:0] smpl_r;
    logic [2:0] range_r;
    logic pole_r;
    logic [2:0] tap_r;
    logic [6:0] word_addr;
    logic [2:0] wr_rng;

    assign word_addr = {reg_addr[6:1], 1'b0};
    assign wr_rng = reg_wdata[2:0];

    always_ff @(posedge clk) begin
        if (rst) begin
            smpl_r <= SMPL_RST[7:0];
            range_r <= SENS_RST[10:8];
            pole_r <= SENS_RST[POLE_BIT];
            tap_r <= SENS_RST[2:0];
        end else if (ce && reg_wr) begin
            if (reg_addr == ADDR_SMPL)
                smpl_r <= reg_wdata;                                         // RL11
            if (reg_addr == (ADDR_SENS | 7'h01) &&
                (wr_rng == RNG_80 || wr_rng == RNG_160 || wr_rng == RNG_320)) begin
                range_r <= wr_rng;                                           // RL12
                if (tap_r < min_taps(wr_rng))
                    tap_r <= min_taps(wr_rng);                               // RL13
            end
            if (reg_addr == ADDR_SENS) begin
                pole_r <= reg_wdata[POLE_BIT];                               // RL15
                if (reg_wdata[2:0] < min_taps(range_r))
                    tap_r <= min_taps(range_r);                              // RL14
                else
                    tap_r <= reg_wdata[2:0];                                 // RL16
            end
        end
    end

    assign pole_wide = pole_r;
    assign range_sel = range_r;

    // ****************************************
    // Sample period timer
    // ****************************************
    logic [31:0] per_cnt_r;
    logic tick_r;

    always_ff @(posedge clk) begin
        if (rst) begin
            per_cnt_r <= 32'h0;
            tick_r <= 1'b0;
        end else if (ce) begin
            tick_r <= (per_cnt_r == 32'h0);
            if (per_cnt_r == 32'h0)
                per_cnt_r <= period_cycles(smpl_r) - 32'h1;                  // RL10
            else
                per_cnt_r <= per_cnt_r - 32'h1;
        end
    end

    assign sample_tick = tick_r;

    // ****************************************
    // Two-stage moving average
    // ****************************************
    logic signed [15:0] buf1 [0:127];
    logic signed [15:0] buf2 [0:127];
    logic [6:0] ptr_r;
    logic [7:0] fill_r;
    logic [2:0] tap_last_r;
    logic signed [22:0] sum1_r;
    logic signed [22:0] sum2_r;
    logic signed [15:0] filt_r;
    logic [7:0] ntaps;
    logic [6:0] old_idx;
    logic signed [15:0] old1;
    logic signed [15:0] old2;
    logic signed [22:0] sum1_nxt;
    logic signed [22:0] sum2_nxt;
    logic signed [15:0] avg1;

    assign ntaps = 8'h1 << tap_r;
    assign old_idx = ptr_r - ntaps[6:0];
    assign old1 = (fill_r < ntaps) ? 16'sh0 : buf1[old_idx];
    assign old2 = (fill_r < ntaps) ? 16'sh0 : buf2[old_idx];
    assign sum1_nxt = sum1_r + 23'(raw.rate) - 23'(old1);
    assign avg1 = 16'(sum1_nxt >>> tap_r);
    assign sum2_nxt = sum2_r + 23'(avg1) - 23'(old2);

    always_ff @(posedge clk) begin
        if (ce && raw_valid) begin
            buf1[ptr_r] <= raw.rate;
            buf2[ptr_r] <= avg1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ptr_r <= 7'h0;
            fill_r <= 8'h0;
            tap_last_r <= SENS_RST[2:0];
            sum1_r <= 23'sh0;
            sum2_r <= 23'sh0;
            filt_r <= 16'sh0;
        end else if (ce) begin
            tap_last_r <= tap_r;
            if (tap_last_r != tap_r) begin
                fill_r <= 8'h0;
                sum1_r <= 23'sh0;
                sum2_r <= 23'sh0;
            end else if (raw_valid) begin
                ptr_r <= ptr_r + 7'h1;
                if (fill_r < ntaps)
                    fill_r <= fill_r + 8'h1;
                sum1_r <= sum1_nxt;                                          // RL17
                sum2_r <= sum2_nxt;                                          // RL17
                filt_r <= 16'(sum2_nxt >>> tap_r);                           // RL16
            end
        end
    end

    // ****************************************
    // Angle integration
    // ****************************************
    logic [26:0] ang_acc_r;
    logic signed [27:0] ang_sum;
    logic [13:0] ang_code;
    logic [13:0] ang_wr_code;

    assign ang_sum = $signed({1'b0, ang_acc_r}) + 28'(raw.rate);
    assign ang_code = ang_acc_r[26:ANGLE_FRAC] > 15'(ANGLE_MAX_CODE) ? 14'h0
                      : ang_acc_r[25:ANGLE_FRAC];
    assign ang_wr_code = reg_addr[0] ? {reg_wdata[5:0], ang_code[7:0]}
                                     : {ang_code[13:8], reg_wdata};

    always_ff @(posedge clk) begin
        if (rst) begin
            ang_acc_r <= 27'h0;
        end else if (ce) begin
            if (reg_wr && word_addr == ADDR_ANGLE)
                ang_acc_r <= (ang_wr_code > ANGLE_MAX_CODE) ? 27'h0
                             : {1'b0, ang_wr_code, 12'h0};
            else if (raw_valid && ang_sum < 0)
                ang_acc_r <= 27'(ang_sum + 28'(ANGLE_MOD));                  // RL6
            else if (raw_valid && ang_sum >= 28'(ANGLE_MOD))
                ang_acc_r <= 27'(ang_sum - 28'(ANGLE_MOD));                  // RL6
            else if (raw_valid)
                ang_acc_r <= ang_sum[26:0];
        end
    end

    // ****************************************
    // Output words and new-data flags
    // ****************************************
    logic [11:0] supply_w_r;
    logic [13:0] rate_w_r;
    logic [13:0] angle_w_r;
    logic [11:0] temp_w_r;
    logic [11:0] aux_w_r;
    logic [4:0] nd_r;
    logic [4:0] rd_hit;
    logic ea;

    assign ea = |diagnostic_status;                                          // RL2
    assign rd_hit = {5{reg_rd}} & {word_addr == ADDR_AUX, word_addr == ADDR_TEMP,
                     word_addr == ADDR_ANGLE, word_addr == ADDR_RATE, word_addr == ADDR_SUPPLY};

    always_ff @(posedge clk) begin
        if (rst) begin
            supply_w_r <= 12'h0;
            rate_w_r <= 14'h0;
            angle_w_r <= 14'h0;
            temp_w_r <= 12'h0;
            aux_w_r <= 12'h0;
        end else if (ce && tick_r) begin
            supply_w_r <= raw.supply;                                        // RL4
            rate_w_r <= scale_rate(filt_r, range_r);                         // RL5
            angle_w_r <= ang_code;                                           // RL6
            temp_w_r <= raw.temp;                                            // RL7
            aux_w_r <= raw.aux;                                              // RL8
        end
    end

    always_ff @(posedge clk) begin
        if (rst)
            nd_r <= 5'h0;
        else if (ce)
            nd_r <= (nd_r & ~rd_hit) | {5{tick_r}};                          // RL1
    end

    // ****************************************
    // Register read port
    // ****************************************
    logic [15:0] rd_word;

    always_comb begin
        rd_word = 16'h0;
        case (word_addr)
            ADDR_SUPPLY: rd_word = {nd_r[0], ea, 2'h0, supply_w_r};          // RL3
            ADDR_RATE: rd_word = {nd_r[1], ea, rate_w_r};                    // RL3
            ADDR_ANGLE: rd_word = {nd_r[2], ea, angle_w_r};                  // RL3
            ADDR_TEMP: rd_word = {nd_r[3], ea, 2'h0, temp_w_r};              // RL3
            ADDR_AUX: rd_word = {nd_r[4], ea, 2'h0, aux_w_r};                // RL3
            ADDR_SMPL: rd_word = {8'h0, smpl_r};
            ADDR_SENS: rd_word = {5'h0, range_r, pole_r, 4'h0, tap_r};
            ADDR_DIAG: rd_word = diagnostic_status;
            default: rd_word = 16'h0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            reg_rdata <= 16'h0;
            reg_rvalid <= 1'b0;
        end else if (ce) begin
            reg_rvalid <= reg_rd;
            if (reg_rd)
                reg_rdata <= rd_word;
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    sequence s_tick;
        ce && tick_r;
    endsequence

    property p_nd_set;
        @(posedge clk) disable iff (rst) s_tick |=> nd_r == 5'h1f;
    endproperty
    a_nd_set: assert property (p_nd_set) else $error("new-data not set"); // RL1

    property p_nd_clr;
        @(posedge clk) disable iff (rst)
        ce && rd_hit[1] && !tick_r |=> !nd_r[1] && reg_rdata[ND_BIT] == $past(nd_r[1]);
    endproperty
    a_nd_clr: assert property (p_nd_clr) else $error("new-data not cleared"); // RL3

    property p_ea;
        @(posedge clk) disable iff (rst)
        ce && |rd_hit |=> reg_rdata[EA_BIT] == |$past(diagnostic_status);
    endproperty
    a_ea: assert property (p_ea) else $error("error flag mismatch"); // RL2

    property p_supply;
        @(posedge clk) disable iff (rst) s_tick |=> supply_w_r == $past(raw.supply);
    endproperty
    a_supply: assert property (p_supply) else $error("supply word wrong"); // RL4

    property p_rate;
        @(posedge clk) disable iff (rst)
        s_tick |=> rate_w_r == scale_rate($past(filt_r), $past(range_r));
    endproperty
    a_rate: assert property (p_rate) else $error("rate word wrong"); // RL5

    property p_angle;
        @(posedge clk) disable iff (rst) angle_w_r <= ANGLE_MAX_CODE && ang_acc_r < ANGLE_MOD;
    endproperty
    a_angle: assert property (p_angle) else $error("angle out of range"); // RL6

    property p_fast;
        @(posedge clk) disable iff (rst)
        ce && per_cnt_r == 32'h0 && smpl_r == 8'h00 |=> per_cnt_r == 32'(FAST_CYC - 1);
    endproperty
    a_fast: assert property (p_fast) else $error("fast period wrong"); // RL9

    property p_taps160;
        @(posedge clk) disable iff (rst) range_r == RNG_160 |-> tap_r >= MIN_TAP_160;
    endproperty
    a_taps160: assert property (p_taps160) else $error("160 taps too few"); // RL13

    property p_taps80;
        @(posedge clk) disable iff (rst) range_r == RNG_80 |-> tap_r >= MIN_TAP_80;
    endproperty
    a_taps80: assert property (p_taps80) else $error("80 taps too few"); // RL14

    property p_range;
        @(posedge clk) disable iff (rst) range_r inside {RNG_80, RNG_160, RNG_320};
    endproperty
    a_range: assert property (p_range) else $error("illegal range code"); // RL12

endmodule

// ===== gyo_pkg.sv
// Shared constants, types and register map of the gyro output block.
// Assumes a 125 MHz system clock; times are converted to cycles here.
package gyo_pkg;

    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_PERIOD_PS = 8000;
    localparam longint TB_FAST_PS = 64'd1953000000;
    localparam longint TB_SLOW_PS = 64'd60540000000;
    localparam longint FAST_SMPL_PS = 64'd488281250;
    localparam int TB_FAST_CYC = int'(TB_FAST_PS / CLK_PERIOD_PS);
    localparam int TB_SLOW_CYC = int'(TB_SLOW_PS / CLK_PERIOD_PS);
    localparam int FAST_SMPL_CYC = int'(FAST_SMPL_PS / CLK_PERIOD_PS);

    // ****************************************
    // Register byte addresses (low byte)
    // ****************************************
    localparam logic [6:0] ADDR_SUPPLY = 7'h02;
    localparam logic [6:0] ADDR_RATE = 7'h04;
    localparam logic [6:0] ADDR_AUX = 7'h0a;
    localparam logic [6:0] ADDR_TEMP = 7'h0c;
    localparam logic [6:0] ADDR_ANGLE = 7'h0e;
    localparam logic [6:0] ADDR_SMPL = 7'h36;
    localparam logic [6:0] ADDR_SENS = 7'h38;
    localparam logic [6:0] ADDR_DIAG = 7'h3c;

    // ****************************************
    // Fields and reset values
    // ****************************************
    localparam int ND_BIT = 15;
    localparam int EA_BIT = 14;
    localparam int TB_SEL_BIT = 7;
    localparam int POLE_BIT = 7;
    localparam logic [15:0] SMPL_RST = 16'h0001;
    localparam logic [15:0] SENS_RST = 16'h0402;
    localparam logic [2:0] MIN_TAP_160 = 3'h2;
    localparam logic [2:0] MIN_TAP_80 = 3'h4;
    localparam logic [13:0] ANGLE_MAX_CODE = 14'h2663;
    localparam int ANGLE_FRAC = 12;
    localparam logic [26:0] ANGLE_MOD = 27'h2664000;

    typedef enum logic [2:0] {
        RNG_80 = 3'b001,
        RNG_160 = 3'b010,
        RNG_320 = 3'b100
    } gyo_range_type;

    typedef struct packed {
        logic [11:0] supply;
        logic signed [15:0] rate;
        logic [11:0] temp;
        logic [11:0] aux;
    } gyo_raw_type;

endpackage

// ===== gyo_host.sv
// Register port master model that stands in for the host processor.
// Assumes the bench calls its tasks one at a time on a shared clock.
`timescale 1ns/10ps
module gyo_host import gyo_pkg::*; (
    input wire logic clk,
    output logic [6:0] reg_addr,
    output logic reg_wr,
    output logic [7:0] reg_wdata,
    output logic reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic reg_rvalid
);
    // ****************************************
    // Idle state
    // ****************************************
    initial begin
        reg_addr = 7'h00;
        reg_wr = 1'b0;
        reg_wdata = 8'h00;
        reg_rd = 1'b0;
    end

    // ****************************************
    // Byte write and word read
    // ****************************************
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        // Released lines show no stale value
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask

    task automatic rd(input logic [6:0] a, output logic [15:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        // Answer stands in the cycle after the request edge
        @(posedge clk);
        d = reg_rvalid ? reg_rdata : 16'hxxxx;
    endtask
endmodule

// ===== testbench.sv
// Self-checking bench for the gyro output block.
// Assumes short timing parameters so each sample period is tens of cycles.
`timescale 1ns/10ps
module testbench import gyo_pkg::*;;
    logic clk;
    logic rst;
    logic ce;
    logic raw_valid;
    gyo_raw_type raw;
    logic [15:0] diagnostic_status;
    logic [6:0] reg_addr;
    logic reg_wr;
    logic [7:0] reg_wdata;
    logic reg_rd;
    logic [15:0] reg_rdata;
    logic reg_rvalid;
    logic sample_tick;
    logic pole_wide;
    logic [2:0] range_sel;
    logic [15:0] v;
    int bad_count = 0;
    int check_count = 0;
    int cyc = 0;
    int n;
    logic [6:0] sa[6] = '{7'h39, 7'h39, 7'h39, 7'h38, 7'h39, 7'h38};
    logic [7:0] sd[6] = '{8'h02, 8'h01, 8'h03, 8'h81, 8'h04, 8'h03};
    logic [15:0] se[6] = '{16'h0202, 16'h0104, 16'h0104, 16'h0184, 16'h0484, 16'h0403};
    logic [15:0] sr[6] = '{16'h8080, 16'h8100, 16'h8100, 16'h8100, 16'h8040, 16'h8040};
    logic [7:0] pd[4] = '{8'h00, 8'h03, 8'h81, 8'h01};
    int pc[4] = '{24, 40, 80, 20};

    gyo_core #(.FAST_CYC(24), .BASE_FAST_CYC(10), .BASE_SLOW_CYC(40)) gyo_core_i (
        .clk(clk), .rst(rst), .ce(ce), .raw_valid(raw_valid), .raw(raw),
        .diagnostic_status(diagnostic_status), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .sample_tick(sample_tick), .pole_wide(pole_wide),
        .range_sel(range_sel)
    );

    gyo_host gyo_host_i (
        .clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid)
    );

    // ****************************************
    // Clock, timeout and helpers
    // ****************************************
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cyc++;
        if (cyc == 10000) begin
            bad_count++;
            end_sim();
        end
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wait_tick(input int cnt);
        int k;
        for (int i = 0; i < cnt; i++) begin
            k = 0;
            @(negedge clk);
            while (sample_tick !== 1'b1 && k < 300) begin
                @(negedge clk);
                k++;
            end
            if (k >= 300)
                bad_count++;
        end
    endtask

    // ****************************************
    // Test sequence
    // ****************************************
    initial begin
        rst = 1'b1;
        ce = 1'b1;
        raw_valid = 1'b0;
        raw = '0;
        diagnostic_status = 16'h0000;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        raw_valid <= 1'b1;
        gyo_host_i.rd(ADDR_SMPL, v);
        chk(v, 16'h0001);
        gyo_host_i.rd(ADDR_SENS, v);
        chk(v, 16'h0402);
        chk({13'h0, range_sel}, 16'h0004);
        chk({15'h0, pole_wide}, 16'h0000);
        $display("test reset values done");

        raw.supply <= 12'hb33;
        raw.temp <= 12'h227;
        raw.aux <= 12'hfff;
        wait_tick(2);
        gyo_host_i.rd(ADDR_SUPPLY, v);
        chk(v, 16'h8b33);
        gyo_host_i.rd(ADDR_SUPPLY + 7'h01, v);
        chk(v, 16'h0b33);
        gyo_host_i.rd(ADDR_TEMP, v);
        chk(v, 16'h8227);
        gyo_host_i.rd(ADDR_AUX, v);
        chk(v, 16'h8fff);
        diagnostic_status <= 16'h0010;
        wait_tick(1);
        gyo_host_i.rd(ADDR_SUPPLY, v);
        chk(v, 16'hcb33);
        gyo_host_i.rd(ADDR_DIAG, v);
        chk(v, 16'h0010);
        diagnostic_status <= 16'h0000;
        gyo_host_i.rd(7'h06, v);
        chk(v, 16'h0000);
        $display("test output words done");

        // Range first, then tap count
        raw.rate <= 16'sh0100;
        for (int i = 0; i < 6; i++) begin
            gyo_host_i.wr(sa[i], sd[i]);
            wait_tick(3);
            gyo_host_i.rd(ADDR_SENS, v);
            chk(v, se[i]);
            chk({13'h0, range_sel}, {13'h0, se[i][10:8]});
            chk({15'h0, pole_wide}, {15'h0, se[i][7]});
            gyo_host_i.rd(ADDR_RATE, v);
            chk(v, sr[i]);
        end
        raw.rate <= -16'sh0004;
        wait_tick(3);
        gyo_host_i.rd(ADDR_RATE, v);
        chk(v, 16'hbfff);
        $display("test range and filter done");

        for (int i = 0; i < 4; i++) begin
            gyo_host_i.wr(ADDR_SMPL, pd[i]);
            wait_tick(2);
            n = 0;
            do begin
                @(negedge clk);
                n++;
            end while (sample_tick !== 1'b1 && n < 300);
            chk(16'(n), 16'(pc[i]));
        end
        gyo_host_i.wr(ADDR_SMPL + 7'h01, 8'hff);
        gyo_host_i.rd(ADDR_SMPL, v);
        chk(v, 16'h0001);
        ce <= 1'b0;
        n = 0;
        repeat (60) begin
            @(negedge clk);
            if (sample_tick !== 1'b0)
                n++;
        end
        chk(16'(n), 16'h0000);
        @(posedge clk);
        ce <= 1'b1;
        $display("test sample period done");

        raw.rate <= 16'sh0000;
        wait_tick(1);
        gyo_host_i.wr(ADDR_ANGLE, 8'h63);
        gyo_host_i.wr(ADDR_ANGLE + 7'h01, 8'h26);
        wait_tick(2);
        gyo_host_i.rd(ADDR_ANGLE, v);
        chk(v & 16'h3fff, 16'h2663);
        @(posedge clk);
        raw.rate <= 16'sh1000;
        @(posedge clk);
        raw.rate <= 16'sh0000;
        wait_tick(2);
        gyo_host_i.rd(ADDR_ANGLE, v);
        chk(v & 16'h3fff, 16'h0000);
        $display("test angle wrap done");
        end_sim();
    end
endmodule
